// ==== rgbp_pkg.sv ====
package rgbp_pkg;

    // ****************************************************************
    // clock, period and timing
    // ****************************************************************
    localparam int          CLK_HZ     = 10_000_000;
    localparam int          PWM_HZ     = 29_000;
    localparam logic [8:0]  PERIOD_CYC = 9'(CLK_HZ / PWM_HZ);
    localparam int          PSAVE_MS   = 30;
    localparam int          PSAVE_CYC  = PSAVE_MS * (CLK_HZ / 1000);
    localparam int          IDLE_W     = 20;

    // ****************************************************************
    // sizes, codes and reset values
    // ****************************************************************
    localparam int          MAX_MOD    = 12;
    localparam int          MAX_CH     = 3 * MAX_MOD;
    localparam logic [7:0]  RESET_KEY  = 8'hFF;
    localparam logic [2:0]  SYNC_RST   = 3'h0;

    typedef enum logic [2:0] {
        RGBP_SHUTDOWN = 3'b000,
        RGBP_INIT     = 3'b001,
        RGBP_STANDBY  = 3'b010,
        RGBP_NORMAL   = 3'b011,
        RGBP_PSAVE    = 3'b100,
        RGBP_THERMAL  = 3'b101
    } rgbp_mode_t;

    // shared bank colour set, one per position in a module
    typedef struct packed {
        logic [7:0] colour_c;
        logic [7:0] colour_b;
        logic [7:0] colour_a;
        logic [7:0] intensity;
    } rgbp_bank_t;

    // global configuration bits
    typedef struct packed {
        logic chip_en;
        logic dither_en;
        logic log_scale_en;
        logic power_save_en;
        logic max_current_opt;
    } rgbp_cfg_t;

    // whole state of the engine
    typedef struct packed {
        logic [2:0]               en_sy;
        logic [2:0]               uv_sy;
        logic [2:0]               ot_sy;
        logic                     en_f;
        logic                     uv_f;
        logic                     ot_f;
        rgbp_mode_t               mode;
        logic [8:0]               cnt;
        logic [2:0]               frame;
        logic [MAX_CH-1:0][8:0]   lo;
        logic [MAX_CH-1:0][8:0]   hi;
        logic [IDLE_W-1:0]        idle;
        logic [MAX_CH-1:0]        out;
        logic                     analog_on;
        logic                     regs_reset;
        logic                     max_cur;
    } rgbp_state_t;

endpackage

// ==== rgbp_pwm_bank.sv ====
`timescale 1ns/10ps
`default_nettype none
module rgbp_pwm_bank #(
    parameter int                       MODULES      = 12,
    parameter logic [rgbp_pkg::IDLE_W-1:0] PSAVE_CYCLES =
        rgbp_pkg::IDLE_W'(rgbp_pkg::PSAVE_CYC)
) (
    // clock and reset
    input  wire logic                              mclk,
    input  wire logic                              arst_n,
    // pins from outside the clock domain
    input  wire logic                              enable_pin,
    input  wire logic                              uvlo_active,
    input  wire logic                              over_temp,
    // register values and events from the command side
    input  wire logic [3*MODULES-1:0][7:0]         channel_colour_value,
    input  wire logic [MODULES-1:0][7:0]           module_intensity_value,
    input  wire logic [MODULES-1:0]                module_group_select,
    input  wire rgbp_pkg::rgbp_bank_t              bank,
    input  wire rgbp_pkg::rgbp_cfg_t               cfg,
    input  wire logic                              reset_reg_wr,
    input  wire logic [7:0]                        reset_reg_data,
    input  wire logic                              cmd_seen,
    // outputs to current sinks and register file
    output logic [3*MODULES-1:0]                   channel_output,
    output logic                                   max_current_sel,
    output logic                                   analog_on,
    output logic                                   regs_reset,
    output rgbp_pkg::rgbp_mode_t                   mode
);
    import rgbp_pkg::*;

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic [1:0]  rst_sy_q;
    logic        rst_n;

    // assert at once, release after two edges
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sy_q <= 2'h0;
        end else begin
            rst_sy_q <= {rst_sy_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sy_q[1];

    // ****************************************************************
    // duty arithmetic
    // ****************************************************************
    // square-law curve; FFh still maps to FFh
    function automatic logic [7:0] log_map(input logic [7:0] b);
        logic [15:0] sq;
        sq = 16'(b) * 16'(b) + 16'(b);
        return sq[15:8];
    endfunction

    // colour times intensity, top twelve bits; FFh intensity is unity
    function automatic logic [11:0] duty_of(input logic [7:0] c, input logic [7:0] b);
        logic [15:0] p;
        p = 16'(c) * (16'(b) + 16'h1);
        return p[15:4];
    endfunction

    // nine-bit width scaled to clock cycles of one period
    function automatic logic [8:0] to_cycles(input logic [9:0] w);
        logic [18:0] t;
        t = 19'(w) * 19'(PERIOD_CYC);
        return t[17:9];
    endfunction

    // ****************************************************************
    // state update
    // ****************************************************************
    rgbp_state_t s_q;
    rgbp_state_t s_d;
    logic        reset_hit;
    logic        wrap;

    assign reset_hit = reset_reg_wr && (reset_reg_data == RESET_KEY);
    assign wrap      = (s_q.cnt == PERIOD_CYC - 9'h1);

    // one pass computes duties, edges, mode and outputs
    always_comb begin
        logic [7:0]  c;
        logic [7:0]  b;
        logic [11:0] duty;
        logic [9:0]  w;
        logic [8:0]  th;
        logic        any_on;
        c      = 8'h0;
        b      = 8'h0;
        duty   = 12'h0;
        w      = 10'h0;
        th     = 9'h0;
        any_on = 1'b0;
        s_d    = s_q;

        // pins pass three flops; level moves when last two agree
        s_d.en_sy = {s_q.en_sy[1:0], enable_pin};
        s_d.uv_sy = {s_q.uv_sy[1:0], uvlo_active};
        s_d.ot_sy = {s_q.ot_sy[1:0], over_temp};
        if (s_q.en_sy[1] == s_q.en_sy[2]) begin
            s_d.en_f = s_q.en_sy[2];
        end
        if (s_q.uv_sy[1] == s_q.uv_sy[2]) begin
            s_d.uv_f = s_q.uv_sy[2];
        end
        if (s_q.ot_sy[1] == s_q.ot_sy[2]) begin
            s_d.ot_f = s_q.ot_sy[2];
        end

        // free-running period counter and dither frame
        s_d.cnt = wrap ? 9'h0 : s_q.cnt + 9'h1;
        if (wrap) begin
            s_d.frame = s_q.frame + 3'h1;
        end

        for (int i = 0; i < MAX_CH; i++) begin
            if (i < 3 * MODULES) begin
                // bank mode swaps in shared values by position
                if (module_group_select[i / 3]) begin
                    b = bank.intensity;
                    unique case (i % 3)
                        0: c = bank.colour_a;
                        1: c = bank.colour_b;
                        default: c = bank.colour_c;
                    endcase
                end else begin
                    c = channel_colour_value[i];
                    b = module_intensity_value[i / 3];
                end
                if (cfg.log_scale_en) begin
                    b = log_map(b);
                end
                duty = duty_of(c, b);
                any_on = any_on | (duty != 12'h0);
                // fraction f lengthens f of every eight pulses
                w = {1'b0, duty[11:3]};
                if (cfg.dither_en && (s_q.frame < duty[2:0])) begin
                    w = w + 10'h1;
                end
                th = to_cycles(w);
                // edges change only as a new period starts
                if (wrap) begin
                    unique case (i % 3)
                        0: begin
                            s_d.lo[i] = 9'h0;
                            s_d.hi[i] = th;
                        end
                        1: begin
                            s_d.lo[i] = (PERIOD_CYC - th) >> 1;
                            s_d.hi[i] = ((PERIOD_CYC - th) >> 1) + th;
                        end
                        default: begin
                            s_d.lo[i] = PERIOD_CYC - th;
                            s_d.hi[i] = PERIOD_CYC;
                        end
                    endcase
                end
                s_d.out[i] = (s_q.mode == RGBP_NORMAL) &&
                             (s_q.cnt >= s_q.lo[i]) && (s_q.cnt < s_q.hi[i]);
            end
        end

        // idle timer restarts on any lit duty or outside normal
        if (any_on || (s_q.mode != RGBP_NORMAL)) begin
            s_d.idle = '0;
        end else if (s_q.idle != PSAVE_CYCLES) begin
            s_d.idle = s_q.idle + IDLE_W'(1);
        end

        // mode machine; enable low wins over everything
        if (!s_q.en_f) begin
            s_d.mode = RGBP_SHUTDOWN;
        end else if (s_q.uv_f || reset_hit) begin
            s_d.mode = RGBP_INIT;
        end else begin
            unique case (s_q.mode)
                RGBP_SHUTDOWN: s_d.mode = RGBP_INIT;
                RGBP_INIT:     s_d.mode = RGBP_STANDBY;
                RGBP_STANDBY: begin
                    if (cfg.chip_en) begin
                        s_d.mode = RGBP_NORMAL;
                    end
                end
                RGBP_NORMAL: begin
                    if (!cfg.chip_en) begin
                        s_d.mode = RGBP_STANDBY;
                    end else if (s_q.ot_f) begin
                        s_d.mode = RGBP_THERMAL;
                    end else if (cfg.power_save_en && (s_q.idle == PSAVE_CYCLES)) begin
                        s_d.mode = RGBP_PSAVE;
                    end
                end
                RGBP_PSAVE: begin
                    // register file is untouched here, only analog is off
                    if (!cfg.chip_en) begin
                        s_d.mode = RGBP_STANDBY;
                    end else if (cmd_seen) begin
                        s_d.mode = RGBP_NORMAL;
                    end
                end
                RGBP_THERMAL: begin
                    if (!s_q.ot_f) begin
                        s_d.mode = RGBP_NORMAL;
                    end
                end
                default: s_d.mode = RGBP_SHUTDOWN;
            endcase
        end

        // analog and clear outputs follow the next mode; max current follows cfg
        s_d.analog_on  = (s_d.mode == RGBP_NORMAL) || (s_d.mode == RGBP_THERMAL);
        s_d.regs_reset = (s_d.mode == RGBP_INIT);
        s_d.max_cur    = cfg.max_current_opt;
    end

    // single register for the whole state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q       <= '0;
            s_q.en_sy <= SYNC_RST;
            s_q.mode  <= RGBP_SHUTDOWN;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops; unused slots never reach a pin
    assign channel_output  = s_q.out[3*MODULES-1:0];
    assign max_current_sel = s_q.max_cur;
    assign analog_on       = s_q.analog_on;
    assign regs_reset      = s_q.regs_reset;
    assign mode            = s_q.mode;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_period_end;
        s_q.cnt == PERIOD_CYC - 9'h1;
    endsequence

    sequence s_init_done;
        s_q.mode == RGBP_INIT && s_q.en_f && !s_q.uv_f && !reset_hit;
    endsequence

    period_wrap_a: assert property (s_period_end |=> s_q.cnt == 9'h0)
        else $error("period counter did not wrap");

    edge_hold_a: assert property (!$stable(s_q.lo) || !$stable(s_q.hi) |->
        $past(s_q.cnt) == PERIOD_CYC - 9'h1)
        else $error("edges changed inside a period");

    dark_outside_a: assert property (s_q.mode != RGBP_NORMAL |=> s_q.out == '0)
        else $error("output lit outside normal mode");

    pin_shutdown_a: assert property (!s_q.en_f |=> mode == RGBP_SHUTDOWN)
        else $error("enable low did not shut down");

    reset_init_a: assert property (s_q.en_f && reset_hit |=> mode == RGBP_INIT && regs_reset)
        else $error("reset key did not initialize");

    init_standby_a: assert property (s_init_done |=> s_q.mode == RGBP_STANDBY)
        else $error("initialization did not end in standby");

    chip_start_a: assert property (s_q.mode == RGBP_STANDBY && cfg.chip_en && s_q.en_f &&
        !s_q.uv_f && !reset_hit |=> mode == RGBP_NORMAL ##1 analog_on)
        else $error("chip enable did not start normal mode");

    thermal_off_a: assert property (s_q.mode == RGBP_NORMAL && s_q.ot_f && cfg.chip_en &&
        s_q.en_f && !s_q.uv_f && !reset_hit |=> mode == RGBP_THERMAL ##1 s_q.out == '0)
        else $error("over-temperature left outputs on");

    psave_entry_a: assert property ($past(s_q.mode) == RGBP_NORMAL && s_q.mode == RGBP_PSAVE |->
        $past(cfg.power_save_en) && $past(s_q.idle) == PSAVE_CYCLES)
        else $error("power save entered early");

    psave_wake_a: assert property (s_q.mode == RGBP_PSAVE && cmd_seen && cfg.chip_en &&
        s_q.en_f && !s_q.uv_f && !reset_hit |=> mode == RGBP_NORMAL)
        else $error("command did not wake from power save");

endmodule
`default_nettype wire

// ==== rgbp_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// register image kept by the host side, cleared by the device
// ****************************************************************
module rgbp_host_model #(
    parameter int MODULES = 12
) (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      arst_n,
    // bench writes and device clear request
    input  wire logic                      load,
    input  wire logic                      regs_reset,
    input  wire logic [3*MODULES-1:0][7:0] w_col,
    input  wire logic [MODULES-1:0][7:0]   w_int,
    input  wire logic [MODULES-1:0]        w_grp,
    input  wire rgbp_pkg::rgbp_bank_t      w_bank,
    input  wire rgbp_pkg::rgbp_cfg_t       w_cfg,
    // register image seen by the device
    output logic [3*MODULES-1:0][7:0]      col,
    output logic [MODULES-1:0][7:0]        inten,
    output logic [MODULES-1:0]             grp,
    output rgbp_pkg::rgbp_bank_t           bank,
    output rgbp_pkg::rgbp_cfg_t            cfg,
    output logic                           cmd
);
    import rgbp_pkg::*;

    // every write is also an addressed command; image survives standby
    // async branch holds constants only; device clear is synchronous
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            col   <= '0;
            inten <= {MODULES{8'hFF}};
            grp   <= '0;
            bank  <= 32'h000000FF;
            cfg   <= 5'h0A;
            cmd   <= 1'b0;
        end else if (regs_reset) begin
            col   <= '0;
            inten <= {MODULES{8'hFF}};
            grp   <= '0;
            bank  <= 32'h000000FF;
            cfg   <= 5'h0A;
            cmd   <= 1'b0;
        end else begin
            cmd <= load;
            if (load) begin
                col   <= w_col;
                inten <= w_int;
                grp   <= w_grp;
                bank  <= w_bank;
                cfg   <= w_cfg;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb_rgb_led_pwm_bank_controller.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_rgb_led_pwm_bank_controller;
    import rgbp_pkg::*;
    localparam int M = 12;
    localparam int N = 3 * M;
    localparam int P = int'(PERIOD_CYC);
    // ****************************************************************
    // stimulus, image and device signals
    // ****************************************************************
    logic mclk = 1'b0, arst_n = 1'b0, enable_pin = 1'b0, uvlo = 1'b0;
    logic hot = 1'b0, load = 1'b0, rwr = 1'b0;
    logic [7:0] rdat = 8'h00;
    logic [N-1:0][7:0] w_col = '0, col;
    logic [M-1:0][7:0] w_int = '1, inten;
    logic [M-1:0] w_grp = '0, grp;
    rgbp_bank_t w_bank = '0, bank;
    rgbp_cfg_t w_cfg = '0, cfg;
    logic cmd, max_current_sel, analog_on, regs_reset;
    logic [N-1:0] channel_output;
    rgbp_mode_t mode;
    int errors = 0, checks = 0, seed = 32'h9c1c;

    rgbp_host_model #(.MODULES(M)) host (.mclk(mclk), .arst_n(arst_n), .load(load),
        .regs_reset(regs_reset), .w_col(w_col), .w_int(w_int), .w_grp(w_grp),
        .w_bank(w_bank), .w_cfg(w_cfg), .col(col), .inten(inten), .grp(grp),
        .bank(bank), .cfg(cfg), .cmd(cmd));
    // short idle count keeps the power-save wait small
    rgbp_pwm_bank #(.MODULES(M), .PSAVE_CYCLES(20'h32)) dut (.mclk(mclk),
        .arst_n(arst_n), .enable_pin(enable_pin), .uvlo_active(uvlo),
        .over_temp(hot), .channel_colour_value(col), .module_intensity_value(inten),
        .module_group_select(grp), .bank(bank), .cfg(cfg), .reset_reg_wr(rwr),
        .reset_reg_data(rdat), .cmd_seen(cmd), .channel_output(channel_output),
        .max_current_sel(max_current_sel), .analog_on(analog_on),
        .regs_reset(regs_reset), .mode(mode));

    initial begin
        forever #50 mclk = ~mclk;
    end
    // ****************************************************************
    // expectations and helpers
    // ****************************************************************
    function automatic logic [11:0] duty(input logic [7:0] c, b, input logic lg);
        logic [15:0] m;
        m = lg ? ((16'(b) * 16'(b) + 16'(b)) >> 8) : 16'(b);
        return 12'((20'(c) * (20'(m) + 20'h1)) >> 4);
    endfunction
    function automatic logic [11:0] chduty(input int i);
        if (w_grp[i/3])
            return duty(w_bank[8*(i%3)+8 +: 8], w_bank.intensity, w_cfg.log_scale_en);
        return duty(w_col[i], w_int[i/3], w_cfg.log_scale_en);
    endfunction
    function automatic int th(input logic [11:0] d);
        return (int'(d[11:3]) * P) >> 9;
    endfunction
    // eight periods cover every dither frame once
    function automatic int hsum(input logic [11:0] d, input logic de);
        int s;
        s = 0;
        for (int f = 0; f < 8; f++)
            s += ((int'(d[11:3]) + int'(de && f < d[2:0])) * P) >> 9;
        return s;
    endfunction
    task automatic chk(input logic [31:0] got, exp, input string msg);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask
    task automatic put();
        load = 1'b1;
        @(negedge mclk);
        load = 1'b0;
        @(negedge mclk);
    endtask
    task automatic rkey(input logic [7:0] v);
        rwr = 1'b1;
        rdat = v;
        @(negedge mclk);
        rwr = 1'b0;
    endtask
    task automatic wait_mode(input rgbp_mode_t m, input int lim);
        for (int t = 0; t < lim && mode !== m; t++) @(negedge mclk);
        chk(32'(mode), 32'(m), "mode");
    endtask
    task automatic quiet();
        logic seen;
        seen = 1'b0;
        repeat (P) begin
            @(negedge mclk);
            seen = seen | (|channel_output);
        end
        chk(32'(seen), 0, "outputs off");
    endtask
    task automatic pwm_run(input logic de, input logic lg);
        int n[N];
        int fi[N];
        int la[N];
        logic [11:0] d;
        for (int i = 0; i < N; i++) w_col[i] = 8'($random(seed));
        for (int k = 0; k < M; k++) w_int[k] = 8'($random(seed));
        w_col[0] = w_col[0] | 8'h80;  // channel 0 marks the period start
        w_int[0] = 8'hFF;
        w_grp = M'($random(seed)) & ~M'(1);
        w_bank = $random(seed);
        w_cfg = '{1'b1, de, lg, 1'b1, de};
        put();
        chk(32'(max_current_sel), 32'(de), "max current");
        repeat (3 * P) @(negedge mclk);
        for (int i = 0; i < N; i++) begin
            n[i] = 0;
            fi[i] = -1;
            la[i] = -1;
        end
        for (int t = 0; t < 2 * P && channel_output[0] !== 1'b0; t++) @(negedge mclk);
        for (int t = 0; t < 2 * P && channel_output[0] !== 1'b1; t++) @(negedge mclk);
        for (int t = 0; t < 8 * P; t++) begin
            for (int i = 0; i < N; i++)
                if (channel_output[i] === 1'b1) begin
                    n[i]++;
                    if (t < P && fi[i] < 0) fi[i] = t;
                    if (t < P) la[i] = t;
                end
            @(negedge mclk);
        end
        for (int i = 0; i < N; i++) begin
            d = chduty(i);
            chk(n[i], hsum(d, de), "high time");
            if (th(d) > 0) begin
                if (i % 3 == 0) chk(fi[i], 0, "lead edge");
                if (i % 3 == 2) chk(la[i], P - 1, "trail edge");
                if (i % 3 == 1 && !de) chk(fi[i], (P - th(d)) / 2, "centre");
            end
        end
        $display("test pwm done");
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        #(40000 * 100);
        errors++;
        final_report();
    end
    initial begin
        repeat (6) @(negedge mclk);
        arst_n = 1'b1;
        repeat (2) @(negedge mclk);
        enable_pin = 1'b1;
        wait_mode(RGBP_INIT, 10);
        chk(32'(regs_reset), 1, "clear");
        wait_mode(RGBP_STANDBY, 2);
        w_cfg = 5'h1A;
        put();
        wait_mode(RGBP_NORMAL, 5);
        chk(32'(analog_on), 1, "analog");
        $display("test modes done");
        pwm_run(1'b1, 1'b0);
        pwm_run(1'b0, 1'b1);
        hot = 1'b1;
        wait_mode(RGBP_THERMAL, 10);
        quiet();
        hot = 1'b0;
        wait_mode(RGBP_NORMAL, 10);
        w_col = '0;
        w_grp = '0;
        put();
        wait_mode(RGBP_PSAVE, 1000);
        chk(32'(analog_on), 0, "power save");
        put();
        wait_mode(RGBP_NORMAL, 5);
        $display("test power save done");
        w_cfg.chip_en = 1'b0;
        put();
        wait_mode(RGBP_STANDBY, 5);
        quiet();
        rkey(8'h7F);
        repeat (5) @(negedge mclk);
        chk(32'(mode), 32'(RGBP_STANDBY), "wrong key");
        rkey(8'hFF);
        wait_mode(RGBP_INIT, 5);
        wait_mode(RGBP_STANDBY, 5);
        uvlo = 1'b1;
        wait_mode(RGBP_INIT, 10);
        uvlo = 1'b0;
        wait_mode(RGBP_STANDBY, 10);
        // mid-run reset: dark at once, then the pin path restarts
        arst_n = 1'b0;
        @(negedge mclk);
        chk(32'(mode), 32'(RGBP_SHUTDOWN), "reset mode");
        arst_n = 1'b1;
        wait_mode(RGBP_STANDBY, 15);
        enable_pin = 1'b0;
        wait_mode(RGBP_SHUTDOWN, 10);
        $display("test reset paths done");
        final_report();
    end
endmodule
`default_nettype wire
